// file: fr_lerp.sv
// linear interpolation of speed between two duty breakpoints
`timescale 1ns/100ps
module fr_lerp
   import fr_pkg::*;
(
   input  wire logic [7:0] i_x,
   input  wire logic [7:0] i_x0,
   input  wire logic [7:0] i_x1,
   input  wire logic [7:0] i_y0,
   input  wire logic [7:0] i_y1,
   output logic      [7:0] o_y
);
   logic signed [9:0]  dy;
   logic signed [9:0]  dx;
   logic signed [9:0]  span;
   logic signed [19:0] prod;
   logic signed [19:0] quot;

   // y0 + (y1-y0)*(x-x0)/(x1-x0), a flat span gives y1
   always_comb begin
      dy   = $signed({2'h0, i_y1}) - $signed({2'h0, i_y0});
      dx   = $signed({2'h0, i_x}) - $signed({2'h0, i_x0});
      span = $signed({2'h0, i_x1}) - $signed({2'h0, i_x0});
      prod = dy * dx;
      quot = (span > 0) ? prod / span : 20'(dy);
      o_y  = 8'(quot + $signed({12'h000, i_y0}));
   end
endmodule // fr_lerp

// file: fr_motor_model.sv
// behavioural motor answering speed detect and speed feedback
`timescale 1ns/100ps
module fr_motor_model (
   input  wire logic i_clk, i_drive, i_detect, i_open, i_resync, i_revdrv, i_mv, i_rv,
   output logic      o_done, o_moving, o_spin_rev, o_speed_ok, o_zero_cross
);
   logic [7:0] dcnt_ff, ocnt_ff, zcnt_ff;
   logic       ok_ff;
   // phase timers of the simulated rotor
   always_ff @(posedge i_clk) begin
      dcnt_ff <= i_detect ? dcnt_ff + 8'h01 : 8'h00;
      ocnt_ff <= i_open ? ocnt_ff + 8'h01 : 8'h00;
      zcnt_ff <= i_revdrv ? zcnt_ff + 8'h01 : 8'h00;
      ok_ff   <= i_drive && (ok_ff || ocnt_ff > 8'h08);
   end
   // result valid one cycle, lines toggle outside it
   assign o_done       = i_detect && dcnt_ff == 8'h03;
   assign o_moving     = o_done ? i_mv : dcnt_ff[0];
   assign o_spin_rev   = o_done ? i_rv : ~dcnt_ff[0];
   assign o_speed_ok   = ok_ff || (i_resync && i_mv && !i_rv);
   assign o_zero_cross = zcnt_ff > 8'h08;
endmodule // fr_motor_model

// file: fr_pkg.sv
// constants, register map and state codes for the forward-reverse profile block
package fr_pkg;
   localparam int          DW          = 8;
   localparam int          NREG        = 10;
   // register word indices, byte address is index times four
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_DUTY    = 4'h1;
   localparam logic [3:0]  REG_BP_FWD  = 4'h2;
   localparam logic [3:0]  REG_BP_MID  = 4'h3;
   localparam logic [3:0]  REG_BP_REV  = 4'h4;
   localparam logic [3:0]  REG_SPD_FWD = 4'h5;
   localparam logic [3:0]  REG_SPD_REV = 4'h6;
   localparam logic [3:0]  REG_TIME_SB = 4'h7;
   localparam logic [3:0]  REG_TIME_IN = 4'h8;
   localparam logic [3:0]  REG_STATUS  = 4'h9;
   // writable bits of each register, others read zero
   localparam logic [31:0] MASK_CTRL   = 32'h0000_07ff;
   localparam logic [31:0] MASK_DUTY   = 32'h0000_00ff;
   localparam logic [31:0] MASK_FULL   = 32'hffff_ffff;
   localparam logic [31:0] MASK_3B     = 32'h00ff_ffff;
   localparam logic [31:0] MASK_2B     = 32'h0000_ffff;
   localparam logic [31:0] RST_VAL     = 32'h0000_0000;
   // control field positions
   localparam int          C_PROF      = 0;
   localparam int          C_DIR       = 2;
   localparam int          C_ISD       = 3;
   localparam int          C_RESYNC    = 4;
   localparam int          C_REVDRV    = 5;
   localparam int          C_COAST     = 6;
   localparam int          C_BRAKE     = 7;
   localparam int          C_PREBRK    = 8;
   localparam int          C_METHOD    = 9;
   // profile and start method codes
   localparam logic [1:0]  PROF_FWDREV = 2'h3;
   localparam logic [1:0]  M_ALIGN     = 2'h0;
   localparam logic [1:0]  M_DALIGN    = 2'h1;
   localparam logic [7:0]  DUTY_ZERO   = 8'h00;
   localparam logic [15:0] CNT_ONE     = 16'h0001;

   typedef enum logic [8:0] {
      ST_IDLE   = 9'h001,
      ST_DETECT = 9'h002,
      ST_COAST  = 9'h004,
      ST_BRAKE  = 9'h008,
      ST_INIT   = 9'h010,
      ST_OPEN   = 9'h020,
      ST_RESYNC = 9'h040,
      ST_REVDEC = 9'h080,
      ST_CLOSED = 9'h100
   } state_t;
endpackage

// file: fr_profile_start.sv
// forward-reverse speed profile and start-up path selection
// What this block does
// [RULE_01] profile code 3 selects forward-reverse; duty alone sets direction
// [RULE_02] direction flips at the direction-change duty breakpoint
// [RULE_03] from zero speed, duty above forward turn-on starts forward drive
// [RULE_04] below forward turn-off, speed is the larger of off and clamp
// [RULE_05] forward clamp speed holds from turn-off to clamp breakpoint
// [RULE_06] forward speed ramps linearly from clamp breakpoint to breakpoint A
// [RULE_07] speed A holds up to breakpoint B; above B the drive is off
// [RULE_08] above breakpoint D run reverse at speed D up to breakpoint E
// [RULE_09] reverse ramps from E to clamp breakpoint, then holds clamp speed
// [RULE_10] from zero speed, duty below reverse turn-on starts reverse drive
// [RULE_11] above reverse turn-off, reverse speed becomes reverse off speed
// [RULE_12] spin with command is forward, against command is reverse
// [RULE_13] stationary motor: align, double align, position detect or slow cycle
// [RULE_14] slow first cycle applies one low frequency electrical cycle
// [RULE_15] optional brake before the stationary start method
// [RULE_16] forward spin: resync to closed loop, or open loop if slow
// [RULE_17] resync disabled: coast and/or brake, then stationary start
// [RULE_18] reverse spin with reverse drive: decelerate through zero, go on
// [RULE_19] reverse spin without reverse drive: coast/brake, stationary start
// [RULE_20] a zero duty command always stops the motor
// [RULE_21] between breakpoints B and D the speed is zero and drive off
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module fr_profile_start
   import fr_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   // wishbone classic slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // initial speed detect results, speed-ok and zero-cross feedback
   input  wire logic        i_isd_done,
   input  wire logic        i_isd_moving,
   input  wire logic        i_isd_spin_rev,
   input  wire logic        i_speed_ok,
   input  wire logic        i_zero_cross,
   // drive paths
   output logic      [7:0]  o_speed_ref,
   output logic             o_dir_rev,
   output logic             o_drive_on,
   output logic             o_detect,
   output logic             o_coast,
   output logic             o_brake,
   output logic             o_init,
   output logic      [1:0]  o_init_method,
   output logic             o_open_loop,
   output logic             o_resync,
   output logic             o_rev_drive,
   output logic             o_closed_loop
);
   logic [31:0] cfg_ff [NREG];
   logic [31:0] rdat_ff;
   logic        ack_ff;
   logic [3:0]  widx;
   logic        req;
   logic        fwd_ff;
   logic        rev_ff;
   logic [7:0]  spd_ff;
   logic        dir_ff;
   logic        nxt_fwd;
   logic        nxt_rev;
   logic [7:0]  nxt_spd;
   logic [7:0]  fwd_map;
   logic [7:0]  rev_map;
   logic [7:0]  fwd_ramp;
   logic [7:0]  rev_ramp;
   state_t      state_ff;
   state_t      nxt_state;
   logic        align2_ff;
   logic        nxt_align2;
   logic        tmr_load;
   logic [15:0] tmr_count;
   logic        tmr_done;
   logic        run;
   logic        spin_rev_vs_cmd;

   // writable bits of a register word
   function automatic logic [31:0] wmask(input logic [3:0] idx);
      unique case (idx)
         REG_CTRL:    wmask = MASK_CTRL;
         REG_DUTY:    wmask = MASK_DUTY;
         REG_BP_FWD,
         REG_BP_MID,
         REG_SPD_FWD,
         REG_TIME_SB: wmask = MASK_FULL;
         REG_BP_REV:  wmask = MASK_3B;
         REG_SPD_REV,
         REG_TIME_IN: wmask = MASK_2B;
         default:     wmask = 32'h0000_0000;
      endcase
   endfunction

   // byte lane select expanded to a bit mask
   function automatic logic [31:0] lanes(input logic [3:0] sel);
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // control fields
   logic [1:0]  prof;
   logic        dir_cmd;
   logic        isd_en;
   logic        resync_en;
   logic        rev_drive_en;
   logic        coast_en;
   logic        brake_en;
   logic        prebrake_en;
   logic [1:0]  start_method;
   logic [7:0]  duty;
   assign prof         = cfg_ff[REG_CTRL][C_PROF+:2];
   assign dir_cmd      = cfg_ff[REG_CTRL][C_DIR];
   assign isd_en       = cfg_ff[REG_CTRL][C_ISD];
   assign resync_en    = cfg_ff[REG_CTRL][C_RESYNC];
   assign rev_drive_en = cfg_ff[REG_CTRL][C_REVDRV];
   assign coast_en     = cfg_ff[REG_CTRL][C_COAST];
   assign brake_en     = cfg_ff[REG_CTRL][C_BRAKE];
   assign prebrake_en  = cfg_ff[REG_CTRL][C_PREBRK];
   assign start_method = cfg_ff[REG_CTRL][C_METHOD+:2];
   assign duty         = cfg_ff[REG_DUTY][7:0];

   // duty breakpoints
   logic [7:0]  fwd_turn_on_breakpoint;
   logic [7:0]  fwd_turn_off_breakpoint;
   logic [7:0]  fwd_clamp_breakpoint;
   logic [7:0]  bp_a;
   logic [7:0]  bp_b;
   logic [7:0]  bp_dirchg;
   logic [7:0]  bp_d;
   logic [7:0]  bp_e;
   logic [7:0]  rev_clamp_breakpoint;
   logic [7:0]  rev_turn_on_breakpoint;
   logic [7:0]  rev_turn_off_breakpoint;
   assign fwd_turn_on_breakpoint  = cfg_ff[REG_BP_FWD][7:0];
   assign fwd_turn_off_breakpoint = cfg_ff[REG_BP_FWD][15:8];
   assign fwd_clamp_breakpoint    = cfg_ff[REG_BP_FWD][23:16];
   assign bp_a                    = cfg_ff[REG_BP_FWD][31:24];
   assign bp_b                    = cfg_ff[REG_BP_MID][7:0];
   assign bp_dirchg               = cfg_ff[REG_BP_MID][15:8];
   assign bp_d                    = cfg_ff[REG_BP_MID][23:16];
   assign bp_e                    = cfg_ff[REG_BP_MID][31:24];
   assign rev_clamp_breakpoint    = cfg_ff[REG_BP_REV][7:0];
   assign rev_turn_on_breakpoint  = cfg_ff[REG_BP_REV][15:8];
   assign rev_turn_off_breakpoint = cfg_ff[REG_BP_REV][23:16];

   // speeds and phase times
   logic [7:0]  fwd_off_speed;
   logic [7:0]  fwd_clamp_speed;
   logic [7:0]  speed_a;
   logic [7:0]  speed_d;
   logic [7:0]  rev_clamp_speed;
   logic [7:0]  rev_off_speed;
   logic [15:0] coast_time;
   logic [15:0] brake_time;
   logic [15:0] init_time;
   assign fwd_off_speed   = cfg_ff[REG_SPD_FWD][7:0];
   assign fwd_clamp_speed = cfg_ff[REG_SPD_FWD][15:8];
   assign speed_a         = cfg_ff[REG_SPD_FWD][23:16];
   assign speed_d         = cfg_ff[REG_SPD_FWD][31:24];
   assign rev_clamp_speed = cfg_ff[REG_SPD_REV][7:0];
   assign rev_off_speed   = cfg_ff[REG_SPD_REV][15:8];
   assign coast_time      = cfg_ff[REG_TIME_SB][15:0];
   assign brake_time      = cfg_ff[REG_TIME_SB][31:16];
   assign init_time       = cfg_ff[REG_TIME_IN][15:0];

   // bus request decode
   assign req  = i_wb_cyc && i_wb_stb && !ack_ff;
   assign widx = i_wb_adr[5:2];

   // acknowledge one cycle after the request, drop it next cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst)
         ack_ff <= 1'b0;
      else if (i_ce)
         ack_ff <= req;
   end

   // register writes at the ack edge, unmapped words ignored
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         for (int i = 0; i < NREG; i++)
            cfg_ff[i] <= RST_VAL;
      end else if (i_ce && i_wb_cyc && i_wb_stb && ack_ff && i_wb_we && i_wb_adr[7:6] == 2'h0) begin
         for (int i = 0; i < NREG; i++) begin
            if (widx == 4'(i))
               cfg_ff[i] <= (cfg_ff[i] & ~(wmask(widx) & lanes(i_wb_sel)))
                          | (i_wb_dat & wmask(widx) & lanes(i_wb_sel));
         end
      end
   end

   // read data, status shows the block's own state, unmapped reads zero
   always_ff @(posedge i_clk) begin
      if (!i_nrst)
         rdat_ff <= 32'h0000_0000;
      else if (i_ce && req) begin
         if (i_wb_adr[7:6] != 2'h0)
            rdat_ff <= 32'h0000_0000;
         else if (widx == REG_STATUS)
            rdat_ff <= {13'h0000, state_ff, fwd_ff | rev_ff, dir_ff, spd_ff};
         else
            rdat_ff <= cfg_ff[widx] & wmask(widx);
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;

   // ramp segments of both directions
   fr_lerp u_fwd_ramp (
      .i_x  (duty),
      .i_x0 (fwd_clamp_breakpoint),
      .i_x1 (bp_a),
      .i_y0 (fwd_clamp_speed),
      .i_y1 (speed_a),
      .o_y  (fwd_ramp)
   );

   fr_lerp u_rev_ramp (
      .i_x  (duty),
      .i_x0 (bp_e),
      .i_x1 (rev_clamp_breakpoint),
      .i_y0 (speed_d),
      .i_y1 (rev_clamp_speed),
      .o_y  (rev_ramp)
   );

   // forward speed for the present duty
   always_comb begin
      if (duty < fwd_turn_off_breakpoint)
         fwd_map = (fwd_off_speed > fwd_clamp_speed) ?
                   fwd_off_speed : fwd_clamp_speed;            // [RULE_04]
      else if (duty <= fwd_clamp_breakpoint)
         fwd_map = fwd_clamp_speed;                            // [RULE_05]
      else if (duty <= bp_a)
         fwd_map = fwd_ramp;                                   // [RULE_06]
      else
         fwd_map = speed_a;                                    // [RULE_07]
   end

   // reverse speed for the present duty
   always_comb begin
      if (duty > rev_turn_off_breakpoint)
         rev_map = rev_off_speed;                              // [RULE_11]
      else if (duty > rev_clamp_breakpoint)
         rev_map = rev_clamp_speed;                            // [RULE_09]
      else if (duty > bp_e)
         rev_map = rev_ramp;                                   // [RULE_09]
      else
         rev_map = speed_d;                                    // [RULE_08]
   end

   // run state and speed reference, off is passed between directions in the forward-reverse profile
   always_comb begin
      nxt_fwd = fwd_ff;
      nxt_rev = rev_ff;
      nxt_spd = DUTY_ZERO;
      if (prof != PROF_FWDREV) begin
         nxt_fwd = !dir_cmd;
         nxt_rev = dir_cmd;
         nxt_spd = duty;
      end else begin                                          // [RULE_01]
         if (!fwd_ff && !rev_ff) begin
            nxt_fwd = duty > fwd_turn_on_breakpoint && duty <= bp_b
                      && duty <= bp_dirchg;                   // [RULE_03] [RULE_02]
            nxt_rev = duty < rev_turn_on_breakpoint && duty >= bp_d
                      && duty > bp_dirchg;                    // [RULE_10] [RULE_02]
         end else if (fwd_ff && duty > bp_b)
            nxt_fwd = 1'b0;                                   // [RULE_07] [RULE_21]
         else if (rev_ff && duty < bp_d)
            nxt_rev = 1'b0;                                   // [RULE_08] [RULE_21]
         if (nxt_fwd)
            nxt_spd = fwd_map;
         else if (nxt_rev)
            nxt_spd = rev_map;
      end
      if (duty == DUTY_ZERO) begin
         nxt_fwd = 1'b0;                                      // [RULE_20]
         nxt_rev = 1'b0;
         nxt_spd = DUTY_ZERO;
      end
   end

   // profile registers, direction kept from the last running state
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         fwd_ff <= 1'b0;
         rev_ff <= 1'b0;
         spd_ff <= DUTY_ZERO;
         dir_ff <= 1'b0;
      end else if (i_ce) begin
         fwd_ff <= nxt_fwd;
         rev_ff <= nxt_rev;
         spd_ff <= nxt_spd;
         if (nxt_fwd || nxt_rev)
            dir_ff <= nxt_rev;
      end
   end

   assign run = fwd_ff || rev_ff;
   // measured spin against the commanded direction
   assign spin_rev_vs_cmd = i_isd_spin_rev != dir_ff;         // [RULE_12]

   // start-up path selection
   always_comb begin
      nxt_state  = state_ff;
      nxt_align2 = align2_ff;
      unique case (state_ff)
         ST_IDLE: begin
            nxt_align2 = 1'b0;
            if (run) begin
               if (isd_en)
                  nxt_state = ST_DETECT;
               else if (prebrake_en && brake_en)
                  nxt_state = ST_BRAKE;                       // [RULE_15]
               else
                  nxt_state = ST_INIT;
            end
         end
         ST_DETECT: begin
            if (i_isd_done) begin
               if (!i_isd_moving)
                  nxt_state = (prebrake_en && brake_en) ?
                              ST_BRAKE : ST_INIT;             // [RULE_15] [RULE_13]
               else if (!spin_rev_vs_cmd && resync_en)
                  nxt_state = ST_RESYNC;                      // [RULE_16]
               else if (spin_rev_vs_cmd && rev_drive_en)
                  nxt_state = ST_REVDEC;                      // [RULE_18]
               else if (coast_en)
                  nxt_state = ST_COAST;                       // [RULE_17] [RULE_19]
               else if (brake_en)
                  nxt_state = ST_BRAKE;                       // [RULE_17] [RULE_19]
               else
                  nxt_state = ST_INIT;
            end
         end
         ST_COAST: begin
            if (tmr_done)
               nxt_state = brake_en ? ST_BRAKE : ST_INIT;     // [RULE_17] [RULE_19]
         end
         ST_BRAKE: begin
            if (tmr_done)
               nxt_state = ST_INIT;                           // [RULE_15]
         end
         ST_INIT: begin
            if (tmr_done) begin
               if (start_method == M_DALIGN && !align2_ff)
                  nxt_align2 = 1'b1;                          // [RULE_13]
               else
                  nxt_state = ST_OPEN;                        // [RULE_13] [RULE_14]
            end
         end
         ST_RESYNC: begin
            nxt_state = i_speed_ok ? ST_CLOSED : ST_OPEN;     // [RULE_16]
         end
         ST_REVDEC: begin
            if (i_zero_cross)
               nxt_state = ST_OPEN;                           // [RULE_18]
         end
         ST_OPEN: begin
            if (i_speed_ok)
               nxt_state = ST_CLOSED;                         // [RULE_16]
         end
         ST_CLOSED: nxt_state = ST_CLOSED;
         default:   nxt_state = ST_IDLE;
      endcase
      if (!run)
         nxt_state = ST_IDLE;                                 // [RULE_20] [RULE_21]
   end

   // timer loads on entry to a timed phase and on the second align
   always_comb begin
      tmr_load  = 1'b0;
      tmr_count = init_time;
      if (nxt_state != state_ff || nxt_align2 != align2_ff) begin
         tmr_load = nxt_state == ST_COAST || nxt_state == ST_BRAKE
                    || nxt_state == ST_INIT;
         if (nxt_state == ST_COAST)
            tmr_count = coast_time;
         else if (nxt_state == ST_BRAKE)
            tmr_count = brake_time;
      end
   end

   fr_timer u_phase_timer (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_load  (tmr_load),
      .i_count (tmr_count),
      .o_done  (tmr_done)
   );

   // state register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_ff  <= ST_IDLE;
         align2_ff <= 1'b0;
      end else if (i_ce) begin
         state_ff  <= nxt_state;
         align2_ff <= nxt_align2;
      end
   end

   // drive path outputs, registered alongside the state
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_detect      <= 1'b0;
         o_coast       <= 1'b0;
         o_brake       <= 1'b0;
         o_init        <= 1'b0;
         o_init_method <= M_ALIGN;
         o_open_loop   <= 1'b0;
         o_resync      <= 1'b0;
         o_rev_drive   <= 1'b0;
         o_closed_loop <= 1'b0;
      end else if (i_ce) begin
         o_detect      <= nxt_state == ST_DETECT;
         o_coast       <= nxt_state == ST_COAST;
         o_brake       <= nxt_state == ST_BRAKE;
         o_init        <= nxt_state == ST_INIT;              // [RULE_13] [RULE_14]
         o_init_method <= start_method;
         o_open_loop   <= nxt_state == ST_OPEN;
         o_resync      <= nxt_state == ST_RESYNC;
         o_rev_drive   <= nxt_state == ST_REVDEC;
         o_closed_loop <= nxt_state == ST_CLOSED;
      end
   end

   // speed reference outputs
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_speed_ref <= DUTY_ZERO;
         o_dir_rev   <= 1'b0;
         o_drive_on  <= 1'b0;
      end else if (i_ce) begin
         o_speed_ref <= nxt_spd;
         o_dir_rev   <= (nxt_fwd || nxt_rev) ? nxt_rev : dir_ff;
         o_drive_on  <= nxt_fwd || nxt_rev;
      end
   end
endmodule // fr_profile_start

// file: fr_profile_start_end.sv
// holds no logic

// file: fr_profile_start_monitor.sv
// port assertions for the forward-reverse profile and start-up block
`timescale 1ns/100ps
module fr_profile_start_monitor (
   input wire logic        i_clk, i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
   input wire logic [7:0]  i_wb_adr, o_speed_ref,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic        i_isd_done, i_isd_moving, i_isd_spin_rev, i_speed_ok,
   input wire logic        o_dir_rev, o_drive_on, o_detect, o_coast, o_brake, o_init,
   input wire logic        o_open_loop, o_resync, o_rev_drive, o_closed_loop
);
   // start phase outputs as one vector
   wire logic [7:0] ph = {o_detect, o_coast, o_brake, o_init, o_open_loop, o_resync,
                          o_rev_drive, o_closed_loop};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // bus request, zero duty write, moving motor reported
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_zero;
      s_req ##0 (i_wb_we && i_wb_adr == 8'h04 && i_wb_sel[0] && i_wb_dat[7:0] == 8'h00);
   endsequence
   sequence s_spin;
      o_detect && i_isd_done && i_isd_moving;
   endsequence
   AST_BUS_ACK: assert property (s_req |=> o_wb_ack ##1 !o_wb_ack)
      else $error("ack not one pulse");
   AST_ZERO_STOP: assert property (s_zero |-> ##3 !o_drive_on)
      else $error("zero duty left drive on");
   AST_OFF_SPEED: assert property (!o_drive_on |-> o_speed_ref == 8'h00)
      else $error("speed while off");
   AST_IDLE_OFF: assert property (!o_drive_on |=> ph == 8'h00)
      else $error("phase active while off");
   AST_START: assert property ($rose(o_drive_on) |-> ##1 ph != 8'h00)
      else $error("start path not entered");
   AST_STILL: assert property (o_detect && i_isd_done && !i_isd_moving |=> o_brake || o_init)
      else $error("stationary path missed");
   AST_FWD: assert property (s_spin ##0 i_isd_spin_rev == o_dir_rev |=> !o_detect && !o_rev_drive)
      else $error("forward spin misjudged");
   AST_REV: assert property (s_spin ##0 i_isd_spin_rev != o_dir_rev |=> !o_detect && !o_resync)
      else $error("reverse spin misjudged");
   AST_RESYNC: assert property (o_resync && i_speed_ok |=> o_closed_loop)
      else $error("resync did not close loop");
endmodule // fr_profile_start_monitor
bind fr_profile_start fr_profile_start_monitor u_fr_profile_start_monitor (.*);

// file: fr_profile_start_tb_top.sv
// self-checking bench for the profile and start-up block
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
$display("Error %s expected %h seen %h", n, e, g); end end
module fr_profile_start_tb_top;
   import fr_pkg::*;
   logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, mv = 0, rv = 0;
   logic [7:0]  adr = 8'h00, spd, seen;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [1:0]  meth;
   logic        ack, dir, drv, dt, cs, bk, it, ol, rs, rd, cl, done, mo, sr, ok, zc;
   int          bad_count = 0, comparisons = 0, run = 0, ld = 0, d;
   logic [23:0] tab [9] = '{24'h190003, 24'h190203, 24'h190403, 24'h190603, 24'hb9018b,
                            24'h85201b, 24'hf920cb, 24'h8b302b, 24'hb9308b};
   int          dl [9] = '{'h12, 'h05, 'h60, 'h98, 'ha5, 'he8, 'hd0, 'hfc, 'hb8};
   logic [31:0] cfg [7] = '{32'h80400810, 32'hc0b0a090, 32'h00f8f0e0, 32'h40602030,
                            32'h00005080, 32'h00030004, 32'h00000005};
   always #12.5 clk = ~clk;
   fr_profile_start u_fr_profile_start (.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_isd_done(done),
      .i_isd_moving(mo), .i_isd_spin_rev(sr), .i_speed_ok(ok), .i_zero_cross(zc),
      .o_speed_ref(spd), .o_dir_rev(dir), .o_drive_on(drv), .o_detect(dt), .o_coast(cs),
      .o_brake(bk), .o_init(it), .o_init_method(meth), .o_open_loop(ol),
      .o_resync(rs), .o_rev_drive(rd), .o_closed_loop(cl));
   fr_motor_model u_fr_motor_model (.i_clk(clk), .i_drive(drv), .i_detect(dt), .i_open(ol),
      .i_resync(rs), .i_revdrv(rd), .i_mv(mv), .i_rv(rv), .o_done(done), .o_moving(mo),
      .o_spin_rev(sr), .o_speed_ok(ok), .o_zero_cross(zc));
   // expected speed for the present run state
   function automatic int sref(int x);
      if (run == 1) return x < 'h08 ? 'h30 : x <= 'h40 ? 'h20 : x <= 'h80 ? x - 'h20 : 'h60;
      if (run == 2) return x > 'hf8 ? 'h50 : x > 'he0 ? 'h80 : x > 'hc0 ? 2 * x - 'h140 : 'h40;
      return 0;
   endfunction
   // run state: 0 off, 1 forward, 2 reverse
   task automatic mstep(int x);
      if (x == 0 || (run == 1 && x > 'h90) || (run == 2 && x < 'hb0)) run = 0;
      else if (run == 0) run = (x > 'h10 && x <= 'h90) ? 1 : (x >= 'hb0 && x < 'hf0) ? 2 : 0;
      if (run != 0) ld = run == 2;
   endtask
   // one classic bus cycle, read data left in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict;
   end
   // main sequence
   initial begin
      void'($urandom(32'h47c0));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      wb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl reset", RST_VAL, q)
      foreach (cfg[i]) wb(1'b1, 8'(8 + 4 * i), cfg[i]);
      foreach (tab[i]) begin
         wb(1'b1, 8'h00, {20'h0, tab[i][11:0]});
         wb(1'b0, 8'h00, 32'h0);
         `CHK("ctrl", {20'h0, tab[i][11:0]} & MASK_CTRL, q)
         mv <= tab[i][13];
         rv <= tab[i][12];
         seen = 8'h00;
         wb(1'b1, 8'h04, 32'h50);
         repeat (600) begin
            @(posedge clk);
            seen |= {dt, cs, bk, it, ol, rs, rd, cl};
            if (cl === 1'b1) break;
         end
         `CHK("phases", tab[i][23:16], seen)
         `CHK("method", tab[i][10:9], meth)
         wb(1'b1, 8'h04, 32'h0);
         repeat (2) @(posedge clk);
         `CHK("stop", 1'b0, drv)
      end
      wb(1'b1, 8'h00, 32'h3);
      for (int i = 0; i < 60; i++) begin
         d = i < 9 ? dl[i] : $urandom % 256;
         wb(1'b1, 8'h04, 32'(d));
         repeat (2) mstep(d);
         repeat (2) @(posedge clk);
         `CHK("speed", 8'(sref(d)), spd)
         `CHK("dir", 1'(ld), dir)
         `CHK("drive", 1'(run != 0), drv)
      end
      wb(1'b0, 8'h24, 32'h0);
      `CHK("status", {1'(run != 0), 1'(ld), 8'(sref(d))}, q[9:0])
      wb(1'b0, 8'h28, 32'h0);
      `CHK("unmapped", 32'h0, q)
      give_verdict;
   end
endmodule // fr_profile_start_tb_top

// file: fr_timer.sv
// down counter that times coast, brake and position set-up phases
`timescale 1ns/100ps
module fr_timer
   import fr_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   input  wire logic        i_load,
   input  wire logic [15:0] i_count,
   output logic             o_done
);
   logic [15:0] cnt_ff;
   logic        done_ff;

   // load, count down, pulse once on reaching the end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_ff  <= 16'h0000;
         done_ff <= 1'b0;
      end else if (i_ce) begin
         done_ff <= 1'b0;
         if (i_load) begin
            cnt_ff <= i_count;
            if (i_count == 16'h0000)
               done_ff <= 1'b1;
         end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - CNT_ONE;
            if (cnt_ff == CNT_ONE)
               done_ff <= 1'b1;
         end
      end
   end

   assign o_done = done_ff;
endmodule // fr_timer
